// ==== hdl/ipa_pkg.sv ====
/*
  ipa_pkg: constants and types shared by the interrupt priority and
  acceptance block.
  assumes: single clock domain, sources numbered in default priority order.
*/
package ipa_pkg;
  localparam int IPA_NUM_SRC = 51;
  localparam int IPA_NUM_CPU_SRC = 9;
  localparam int IPA_NUM_SWI = 8;
  localparam int IPA_NUM_IO = 25;
  localparam int IPA_NUM_DMA_END = 8;
  localparam int IPA_NUM_EXT = 9;
  localparam int IPA_NUM_MASKABLE = 41;
  localparam int IPA_IDX_W = 6;
  localparam int IPA_VEC_W = 8;
  localparam int IPA_VEC_STEP = 4;
  localparam logic [2:0] IPA_LVL_NMI = 3'h7;
  localparam logic [2:0] IPA_LVL_OFF = 3'h0;
  localparam logic [2:0] IPA_LVL_MIN = 3'h1;
  localparam logic [2:0] IPA_MASK_RESET = 3'h7;
  localparam logic [1:0] IPA_SIZE_BYTE = 2'h0;
  localparam logic [1:0] IPA_SIZE_WORD = 2'h1;
  localparam logic [1:0] IPA_SIZE_LONG = 2'h2;
  localparam logic [5:0] IPA_NO_SRC = 6'h3f;
  typedef enum logic [1:0] {IPA_MODE_HANDLER, IPA_MODE_DMA} ipa_mode_t;
endpackage

// ==== hdl/ipa_interrupt_priority_acceptance.sv ====
/*
  ipa_interrupt_priority_acceptance: collects 51 interrupt sources, resolves
  the highest pending level, holds the cpu mask level and decides acceptance,
  either to a handler vector or to a micro dma transfer.
  assumes: all requests and cpu strobes are synchronous to clock; the cpu
  core raises its instruction strobes for one cycle each.
*/
// Summary of operation
// - There are 51 sources: 8 software, 1 illegal instruction, 25 io, 8 dma end and 9 pins.
// - Each source has a fixed vector number that no setting changes.
// - Each maskable source takes a programmed level from 1 to 6.
// - Non-maskable sources always sit at level 7, the highest.
// - The highest level among all pending requests is presented to the cpu.
// - A presented request is accepted only when its level is at least the mask level.
// - Software and illegal instruction interrupts are taken whatever the mask level.
// - The set-mask instruction loads its operand, and an absent or zero operand loads 1.
// - The mask-all instruction loads 7, leaving only non-maskable requests acceptable.
// - A newly written mask level governs acceptance from the very next cycle.
// - In micro dma mode an accepted request starts a 1, 2 or 4 byte transfer, no handler.
// - Software may request a micro dma transfer with no source asserting.
// - Reset loads the mask level with 111, blocking every maskable request.
// - On handler acceptance, except of software or illegal instruction sources, the mask becomes the accepted level plus one, held at 7 for level 7.
// - Equal levels resolve to the smaller vector first, and that request is cleared.
// - A maskable source programmed to level 0 or 7 never raises a request.
`timescale 1ns/10ps
`default_nettype none
module ipa_interrupt_priority_acceptance
  import ipa_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  // cpu generated sources: index 0..7 software, 8 illegal instruction
  input wire logic [IPA_NUM_SWI-1:0] swiRequest,
  input wire logic illegalRequest,
  // external pin requests: bit 0 non-maskable pin, bits 1..8 maskable pins
  input wire logic [IPA_NUM_EXT-1:0] externalPinRequests,
  input wire logic [IPA_NUM_IO-1:0] ioRequest,
  input wire logic [IPA_NUM_DMA_END-1:0] dmaEndRequest,
  // programmed level per maskable source, 3 bits each
  input wire logic [3*IPA_NUM_MASKABLE-1:0] sourceLevel,
  // per maskable source: 1 routes it to a micro dma transfer
  input wire logic [IPA_NUM_MASKABLE-1:0] dmaSelect,
  input wire logic [1:0] dmaSize,
  input wire logic softDmaStart,
  input wire logic [IPA_IDX_W-1:0] softDmaSource,
  input wire logic setMaskInstruction,
  input wire logic setMaskHasOperand,
  input wire logic [2:0] setMaskOperand,
  input wire logic maskAllInstruction,
  input wire logic cpuReady,
  output logic [2:0] presentedLevel,
  output logic [2:0] interruptMaskLevel,
  output logic acceptStrobe,
  output logic [IPA_VEC_W-1:0] acceptVector,
  output logic [2:0] acceptLevel,
  output logic dmaStartStrobe,
  output logic [IPA_IDX_W-1:0] dmaStartSource,
  output logic [1:0] dmaStartSize
);

  // pending flags, index = default priority order = vector order
  logic [IPA_NUM_SRC-1:0] pending;
  logic [IPA_NUM_SRC-1:0] raw;
  logic [2:0] level [IPA_NUM_SRC];
  logic [IPA_NUM_SRC-1:0] live;
  logic [IPA_NUM_SRC-1:0] bypassMask;

  // source map: 0..8 cpu, 9 nmi pin, 10..17 pins, 18..42 io, 43..50 dma end
  assign raw = {dmaEndRequest, ioRequest, externalPinRequests, illegalRequest,
    swiRequest};

  genvar g;
  generate
    for (g = 0; g < IPA_NUM_SRC; g++) begin : gSrc
      if (g < IPA_NUM_CPU_SRC + 1) begin : gNmi
        assign level[g] = IPA_LVL_NMI;
        assign live[g] = pending[g];
        assign bypassMask[g] = (g < IPA_NUM_CPU_SRC);
      end else begin : gMask
        localparam int M = g - IPA_NUM_CPU_SRC - 1;
        wire logic [2:0] prog = sourceLevel[3*M +: 3];
        // level 0 and 7 both park the source
        assign level[g] = prog;
        assign live[g] = pending[g] && prog != IPA_LVL_OFF
          && prog != IPA_LVL_NMI;
        assign bypassMask[g] = 1'b0;
      end
    end
  endgenerate

  // highest level, then smallest index; ascending scan with strict compare
  logic [2:0] bestLevel;
  logic [IPA_IDX_W-1:0] bestIdx;
  logic bestValid;
  always_comb begin
    bestLevel = IPA_LVL_OFF;
    bestIdx = IPA_NO_SRC;
    bestValid = 1'b0;
    for (int i = 0; i < IPA_NUM_SRC; i++) begin
      if (live[i] && (!bestValid || level[i] > bestLevel)) begin
        bestLevel = level[i];
        bestIdx = IPA_IDX_W'(i);
        bestValid = 1'b1;
      end
    end
  end

  // a cpu-raised source bypasses the mask but still goes through arbitration
  wire logic bestBypass = bestValid && bypassMask[bestIdx];
  wire logic levelOk = bestLevel >= interruptMaskLevel;
  wire logic takeNow = cpuReady && bestValid && (levelOk || bestBypass);
  wire logic bestIsDma = bestIdx > IPA_IDX_W'(IPA_NUM_CPU_SRC)
    && dmaSelect[bestIdx - IPA_IDX_W'(IPA_NUM_CPU_SRC + 1)];
  wire logic takeHandler = takeNow && !bestIsDma;
  wire logic takeDma = takeNow && bestIsDma;
  // software start only when no hardware acceptance in this cycle
  wire logic softDma = softDmaStart && !takeNow;

  // set-mask with no operand or operand 0 behaves as level 1
  wire logic [2:0] setMaskValue = (!setMaskHasOperand || setMaskOperand == IPA_LVL_OFF)
    ? IPA_LVL_MIN : setMaskOperand;
  wire logic [2:0] raisedMask = (bestLevel == IPA_LVL_NMI) ? IPA_LVL_NMI
    : bestLevel + 3'h1;
  // mask write from the cpu wins over the raise from acceptance
  wire logic [2:0] next_interruptMaskLevel = maskAllInstruction ? IPA_LVL_NMI
    : setMaskInstruction ? setMaskValue
    : (takeHandler && !bestBypass) ? raisedMask
    : interruptMaskLevel;

  // one-hot clear of the granted request; new arrivals win over the clear
  wire logic [IPA_NUM_SRC-1:0] grantClear = takeNow
    ? ({{(IPA_NUM_SRC-1){1'b0}}, 1'b1} << bestIdx) : '0;
  wire logic [IPA_NUM_SRC-1:0] next_pending = (pending & ~grantClear) | raw;

  // vector is a fixed function of the source index
  wire logic [IPA_VEC_W-1:0] bestVector = IPA_VEC_W'(bestIdx * IPA_VEC_STEP);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      pending <= '0;
      interruptMaskLevel <= IPA_MASK_RESET;
    end else begin
      pending <= next_pending;
      interruptMaskLevel <= next_interruptMaskLevel;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      acceptStrobe <= 1'b0;
      acceptVector <= '0;
      acceptLevel <= IPA_LVL_OFF;
      dmaStartStrobe <= 1'b0;
      dmaStartSource <= '0;
      dmaStartSize <= IPA_SIZE_BYTE;
      presentedLevel <= IPA_LVL_OFF;
    end else begin
      presentedLevel <= bestLevel;
      acceptStrobe <= takeHandler;
      dmaStartStrobe <= takeDma || softDma;
      if (takeHandler) begin
        acceptVector <= bestVector;
        acceptLevel <= bestLevel;
      end
      if (takeDma || softDma) begin
        dmaStartSource <= takeDma ? bestIdx : softDmaSource;
        // reserved size code falls back to long transfers
        dmaStartSize <= (dmaSize == IPA_SIZE_BYTE || dmaSize == IPA_SIZE_WORD)
          ? dmaSize : IPA_SIZE_LONG;
      end
    end
  end

endmodule
`default_nettype wire

// ==== verif/ipa_monitor.sv ====
/* ipa_monitor: acceptance and mask checks on the block's ports.
   assumes: bound to the top module, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module ipa_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic setMaskInstruction,
  input wire logic setMaskHasOperand,
  input wire logic [2:0] setMaskOperand,
  input wire logic maskAllInstruction,
  input wire logic [2:0] interruptMaskLevel,
  input wire logic acceptStrobe,
  input wire logic [7:0] acceptVector,
  input wire logic [2:0] acceptLevel,
  input wire logic dmaStartStrobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic setMaskOnly = setMaskInstruction && !maskAllInstruction;
  reset_mask_a: assert property (disable iff (1'b0) !resetn |=> interruptMaskLevel == 3'h7 && !acceptStrobe) else $error("mask not 7 after reset");
  mask_all_a: assert property (maskAllInstruction |=> interruptMaskLevel == 3'h7) else $error("mask-all missed");
  set_one_a: assert property (setMaskOnly && (!setMaskHasOperand || setMaskOperand == 3'h0) |=> interruptMaskLevel == 3'h1) else $error("empty set-mask wrong");
  set_operand_a: assert property (setMaskOnly && setMaskHasOperand && setMaskOperand != 3'h0 |=> interruptMaskLevel == $past(setMaskOperand)) else $error("set-mask wrong");
  accept_gate_a: assert property (acceptStrobe && acceptVector >= 8'h24 |-> acceptLevel >= $past(interruptMaskLevel)) else $error("accepted below mask");
  mask_raise_a: assert property (acceptStrobe && acceptVector >= 8'h24 && !$past(setMaskInstruction) && !$past(maskAllInstruction) |-> interruptMaskLevel == ((acceptLevel == 3'h7) ? 3'h7 : acceptLevel + 3'h1)) else $error("mask not raised");
  nmi_level_a: assert property (acceptStrobe && acceptVector == 8'h24 |-> acceptLevel == 3'h7) else $error("nmi level");
  swi_keep_a: assert property (acceptStrobe && acceptVector < 8'h24 && !$past(setMaskInstruction) && !$past(maskAllInstruction) |-> $stable(interruptMaskLevel)) else $error("swi moved mask");
  vector_fixed_a: assert property (acceptStrobe |-> acceptVector[1:0] == 2'h0 && acceptVector < 8'hcc) else $error("bad vector");
  cover property (acceptStrobe && acceptVector == 8'h24);
  cover property (dmaStartStrobe);
  cover property (setMaskInstruction && !setMaskHasOperand);
endmodule
bind ipa_interrupt_priority_acceptance ipa_monitor mon_u (.*);
`default_nettype wire

// ==== verif/ipa_cpu_model.sv ====
/* ipa_cpu_model: cpu core readiness for accepting interrupts.
   assumes: same clock and reset as the block. */
`timescale 1ns/10ps
`default_nettype none
module ipa_cpu_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic slow,
  output logic cpuReady
);
  // slow: ready every other cycle, as a busy core would be
  always_ff @(posedge clock) cpuReady <= !resetn || !slow || !cpuReady;
endmodule
`default_nettype wire

// ==== verif/ipa_interrupt_priority_acceptance_tb_top.sv ====
/* bench: row table of io requests, then hand tests.
   assumes: cpu model drives cpuReady. */
`timescale 1ns/10ps
`default_nettype none
module ipa_interrupt_priority_acceptance_tb_top;
  import ipa_pkg::*;
  typedef struct packed {logic [4:0] io; logic [2:0] lvl, op; logic h, ok;} ipa_row_t;
  ipa_row_t rows [5] = '{'{0,3,3,1,1}, '{1,6,0,1,1}, '{2,1,0,0,1}, '{3,2,3,1,0}, '{4,6,6,1,1}};
  logic clock = 0, resetn = 0, slow = 0, illegalRequest = 0, softDmaStart = 0, cpuReady;
  logic setMaskInstruction = 0, setMaskHasOperand = 0, maskAllInstruction = 0;
  logic [2:0] setMaskOperand = 0, presentedLevel, interruptMaskLevel, acceptLevel;
  logic [7:0] swiRequest = 0, dmaEndRequest = 0, acceptVector;
  logic [8:0] externalPinRequests = 0;
  logic [24:0] ioRequest = 0;
  logic [122:0] sourceLevel = 0;
  logic [40:0] dmaSelect = 0;
  logic [1:0] dmaSize = 0, dmaStartSize;
  logic [5:0] softDmaSource = 0, dmaStartSource;
  logic acceptStrobe, dmaStartStrobe;
  int errTotal = 0, checkCount = 0, cyc = 0;
  ipa_interrupt_priority_acceptance dut_u (.*);
  ipa_cpu_model cpu_u (.clock, .resetn, .slow, .cpuReady);
  initial forever #2 clock = ~clock;
  always @(posedge clock) if (++cyc == 3000) begin
    errTotal++;
    giveVerdict();
  end
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic setMask(input logic [2:0] op, input logic h);
    @(posedge clock);
    setMaskInstruction <= 1;
    setMaskHasOperand <= h;
    setMaskOperand <= op;
    @(posedge clock);
    setMaskInstruction <= 0;
    @(negedge clock);
    chk(interruptMaskLevel, (h && op) ? op : 3'h1);
  endtask
  task automatic io(input logic [24:0] m, input logic [2:0] lvl);
    @(posedge clock);
    for (int i = 0; i < 25; i++) if (m[i]) sourceLevel[3*(8+i) +: 3] <= lvl;
    ioRequest <= m;
    @(posedge clock);
    ioRequest <= 0;
  endtask
  // bounded: a refused request never strobes
  task automatic waitFor(input logic dma);
    int n;
    for (n = 0; n < 12 && (dma ? dmaStartStrobe : acceptStrobe) !== 1; n++) @(negedge clock);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1;
    @(negedge clock);
    chk(interruptMaskLevel, 3'h7);
    chk(presentedLevel, 3'h0);
    foreach (rows[r]) begin
      setMask(rows[r].op, rows[r].h);
      io(25'h1 << rows[r].io, rows[r].lvl);
      waitFor(0);
      chk(acceptStrobe, rows[r].ok);
      if (rows[r].ok) begin
        chk(acceptVector, 8'(4 * (18 + rows[r].io)));
        chk(interruptMaskLevel, rows[r].lvl + 3'h1);
      end
      $display("test row %0d done", r);
    end
    @(posedge clock);
    slow <= 1;
    @(posedge clock);
    maskAllInstruction <= 1;
    swiRequest <= 8'h06;
    @(posedge clock);
    maskAllInstruction <= 0;
    swiRequest <= 0;
    waitFor(0);
    chk(acceptVector, 8'h04);
    @(negedge clock);
    waitFor(0);
    chk(acceptVector, 8'h08);
    chk(interruptMaskLevel, 3'h7);
    @(posedge clock);
    externalPinRequests <= 9'h001;
    @(posedge clock);
    externalPinRequests <= 0;
    waitFor(0);
    chk(acceptLevel, 3'h7);
    chk(acceptVector, 8'h24);
    $display("test swi and nmi done");
    setMask(3'h6, 1);
    @(posedge clock);
    dmaSelect[15] <= 1;
    dmaSize <= 2'h2;
    io(25'h80, 3'h6);
    waitFor(1);
    chk(dmaStartSource, 8'h19);
    chk(dmaStartSize, 8'h02);
    @(posedge clock);
    softDmaStart <= 1;
    softDmaSource <= 6'h05;
    dmaSize <= 2'h3;
    @(posedge clock);
    softDmaStart <= 0;
    waitFor(1);
    chk(dmaStartSource, 8'h05);
    chk(dmaStartSize, 8'h02);
    @(posedge clock);
    maskAllInstruction <= 1;
    @(posedge clock);
    maskAllInstruction <= 0;
    io(25'h100, 3'h2);
    io(25'h200, 3'h6);
    io(25'h400, 3'h7);
    repeat (3) @(negedge clock);
    chk(presentedLevel, 3'h6);
    $display("test dma and presented done");
    // mid-run reset with parked requests still pending
    @(posedge clock);
    resetn <= 0;
    repeat (2) @(posedge clock);
    resetn <= 1;
    @(negedge clock);
    chk(interruptMaskLevel, 3'h7);
    chk(acceptStrobe, 1'b0);
    repeat (3) @(negedge clock);
    chk(presentedLevel, 3'h0);
    $display("test mid-run reset done");
    giveVerdict();
  end
endmodule
`default_nettype wire
